/* common/eeload_pkg.sv */
// Constants shared by the serial EEPROM loader and its bus engine; the synchroniser uses none.
// Assumes a 100 MHz bridge clock and an open-drain two-wire bus with pull-ups.
package eeload_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Software doubleword at B0h, one register per byte lane
  localparam logic [7:0] OFS_DATA  = 8'hB0;
  localparam logic [7:0] OFS_WADDR = 8'hB1;
  localparam logic [7:0] OFS_SLAVE = 8'hB2;
  localparam logic [7:0] OFS_CSR   = 8'hB3;
  localparam logic [7:0] RST_BYTE  = 8'h00;

  // Control and status bit positions
  localparam int CSR_LOAD_FAULT  = 0;
  localparam int CSR_SW_FAULT    = 1;
  localparam int CSR_PRESENT     = 3;
  localparam int CSR_LOAD_ACTIVE = 4;
  localparam int CSR_SW_ACTIVE   = 5;
  localparam int CSR_TEST        = 6;
  localparam int CSR_SKIP        = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // EEPROM image layout
  localparam logic [6:0] EE_SLAVE_ADDR = 7'h50;
  localparam logic [7:0] EE_WORD_START = 8'h00;
  localparam logic [7:0] EE_FUNC_IND   = 8'h00;
  localparam logic [7:0] EE_COUNT      = 8'h25;
  localparam logic [7:0] EE_END_MARK   = 8'h80;
  localparam logic [5:0] IDX_FUNC      = 6'h00;
  localparam logic [5:0] IDX_COUNT     = 6'h01;
  localparam logic [5:0] IDX_END       = 6'h27;

  // Image byte ranges and their configuration offsets; gaps are not loaded
  localparam int SEG_COUNT = 8;
  localparam logic [5:0] SEG_IDX [SEG_COUNT] =
    '{6'h02, 6'h06, 6'h0D, 6'h0F, 6'h1D, 6'h1E, 6'h20, 6'h23};
  localparam logic [5:0] SEG_LEN [SEG_COUNT] =
    '{6'h04, 6'h06, 6'h02, 6'h0C, 6'h01, 6'h02, 6'h03, 6'h04};
  localparam logic [7:0] SEG_OFS [SEG_COUNT] =
    '{8'h44, 8'hD4, 8'hDC, 8'hC0, 8'hE0, 8'hE2, 8'hE8, 8'hEC};

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int SCL_HZ      = 60_000;
  localparam int SCL_QUARTER = CLK_HZ / (4 * SCL_HZ);
  localparam logic [1:0] PRESENT_SETTLE = 2'h3;
  localparam logic [5:0] STEP_BYTE_LAST = 6'h23;
  localparam logic [5:0] STEP_EDGE_LAST = 6'h02;

  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} bus_op_t;

endpackage

/* design/bit_sync.sv */
// Two-flop synchroniser for a group of independent pin levels.
// Assumes each bit is a slow level; no bus coherency between bits.
module bit_sync
#(
  parameter int WIDTH = 2
)(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("bit_sync WIDTH must be at least 1");
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta <= '1;
      q    <= '1;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* design/serial_bit_engine.sv */
// Two-wire bus engine: start, stop, and nine-bit byte slots with acknowledge.
// Assumes sda_in is already synchronised; drives lines low only, never high.
module serial_bit_engine
#(
  parameter int QUARTER = eeload_pkg::SCL_QUARTER
)(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                cmd_valid,
  input  wire eeload_pkg::bus_op_t cmd_op,
  input  wire logic [7:0]          cmd_byte,
  input  wire logic                cmd_nack,
  input  wire logic                fast,
  input  wire logic                sda_in,
  output logic                     busy,
  output logic                     done,
  output logic [7:0]               rx_byte,
  output logic                     rx_ack,
  output logic                     scl_oe,
  output logic                     sda_oe
);
  import eeload_pkg::*;

  if (QUARTER < 2 || QUARTER > 65535)
  begin : g_bad_quarter
    $error("serial_bit_engine QUARTER out of range");
  end

  logic [15:0] tick_cnt;
  logic [5:0]  step;
  logic [8:0]  shreg;
  logic [8:0]  rx_sh;
  bus_op_t     op;

  wire         tick      = busy && (tick_cnt == 16'h0000);
  wire         is_byte   = (op == OP_WRITE) || (op == OP_READ);
  wire [1:0]   q         = step[1:0];
  wire [5:0]   last      = is_byte ? STEP_BYTE_LAST : STEP_EDGE_LAST;
  // Start: SDA falls while SCL high; stop: SDA rises while SCL high
  wire         scl_low_n = is_byte ? (q == 2'h0 || q == 2'h3)
                         : (op == OP_START) ? (step == 6'h02) : (step == 6'h00);
  wire         sda_low_n = is_byte ? !shreg[8]
                         : (op == OP_START) ? (step != 6'h00) : (step != 6'h02);
  wire [15:0]  reload    = fast ? 16'h0001 : 16'(QUARTER - 1);

  assign rx_byte = rx_sh[8:1];
  assign rx_ack  = !rx_sh[0];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy     <= 1'h0;
      done     <= 1'h0;
      step     <= 6'h00;
      tick_cnt <= 16'h0000;
      op       <= OP_STOP;
      shreg    <= 9'h1FF;
      rx_sh    <= 9'h000;
      scl_oe   <= 1'h0;
      sda_oe   <= 1'h0;
    end
    else
    begin
      done <= 1'h0;
      if (cmd_valid && !busy)
      begin
        busy     <= 1'h1;
        op       <= cmd_op;
        step     <= 6'h00;
        tick_cnt <= reload;
        shreg    <= (cmd_op == OP_WRITE) ? {cmd_byte, 1'h1} : {8'hFF, cmd_nack};
      end
      else if (tick)
      begin
        tick_cnt <= reload;
        scl_oe   <= scl_low_n;
        sda_oe   <= sda_low_n;
        if (is_byte && q == 2'h2)
          rx_sh <= {rx_sh[7:0], sda_in};
        if (is_byte && q == 2'h3)
          shreg <= {shreg[7:0], 1'h1};
        if (step == last)
        begin
          busy <= 1'h0;
          done <= 1'h1;
        end
        else
          step <= step + 6'h01;
      end
      else if (busy)
        tick_cnt <= tick_cnt - 16'h0001;
    end
  end

endmodule

/* design/eeprom_config_loader.sv */
// Serial EEPROM configuration loader and software serial-bus port.
// Assumes a configuration-space write/read strobe port and external pull-ups.
//
// Functional notes
// - Image bytes 02h-05h load subsystem IDs at 44h-47h, low byte first.
// - Image bytes 06h-09h load general control at D4h-D7h.
// - Byte 0Ah loads clock control D8h; byte 0Bh loads clock mask D9h.
// - Byte 0Ch skipped; 0Dh loads DCh, 0Eh loads DDh.
// - Bytes 0Fh-1Ah load control and diagnostic bytes C0h-CBh.
// - Bytes 1Bh-1Ch skipped; 1Dh to E0h; 1Eh-1Fh to E2h-E3h.
// - Bytes 20h-22h load E8h-EAh; bytes 23h-26h load ECh-EFh.
// - EEPROM addressed at fixed slave address 1010 000b.
// - Load-active flag, bit 4, high throughout the download.
// - Load-fault flag, bit 0, reports download outcome.
// - Software port is one doubleword at B0h.
// - Data byte sent on software writes, captured on software reads.
// - Word address byte at B1h sent unless skip option set.
// - Writing slave address and direction at B2h starts a transaction.
// - Status at B3h shows enable, busy, errors, protocol and test bits.
// - Software-busy stays high until the transaction completes.
// - After busy clears, fault flag and read data are valid.
// - Download runs automatically as one multibyte read after reset when present is set.
// - Transfer-fault flag, bit 1, set when a slave fails to acknowledge a software transaction.
// - Bit 7 set drops the word address byte and its acknowledge.
// - At reset release a pulled-up clock line sets present, bit 3.
module eeprom_config_loader
#(
  parameter int QUARTER = eeload_pkg::SCL_QUARTER
)(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             load_wr,
  output logic      [7:0]  load_addr,
  output logic      [7:0]  load_data,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  import eeload_pkg::*;

  typedef enum logic [3:0]
  {
    ST_IDLE, ST_START, ST_DEVW, ST_WADDR, ST_WDATA,
    ST_RSTART, ST_DEVR, ST_RDATA, ST_STOP
  } state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus engine

  logic [1:0] pins_sync;
  logic       eng_busy;
  logic       eng_done;
  logic [7:0] eng_rx;
  logic       eng_ack;
  bus_op_t    cmd_op;
  logic [7:0] cmd_byte;
  logic       cmd_nack;
  logic       eng_issue;

  bit_sync #(.WIDTH(2)) u_sync
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({scl_i, sda_i}),
    .q       (pins_sync)
  );

  wire scl_in = pins_sync[1];
  wire sda_in = pins_sync[0];

  logic data_cap;
  logic test_mode;

  serial_bit_engine #(.QUARTER(QUARTER)) u_engine
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .cmd_valid (eng_issue),
    .cmd_op    (cmd_op),
    .cmd_byte  (cmd_byte),
    .cmd_nack  (cmd_nack),
    .fast      (test_mode),
    .sda_in    (sda_in),
    .busy      (eng_busy),
    .done      (eng_done),
    .rx_byte   (eng_rx),
    .rx_ack    (eng_ack),
    .scl_oe    (scl_oe),
    .sda_oe    (sda_oe)
  );

  // Open drain: only ever pull low
  assign scl_o = 1'h0;
  assign sda_o = 1'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [7:0] data_byte;
  logic [7:0] word_address;
  logic [7:0] slave_cmd;
  logic       load_fault;
  logic       sw_fault;
  logic       present;
  logic       load_active;
  logic       sw_active;
  logic       skip_word_address;
  logic       skip_q;
  logic       loading;
  logic       issued;
  logic       abort;
  logic [5:0] idx;
  logic [1:0] settle;
  logic       strap_done;
  state_t     state;
  state_t     next_state;

  wire        dw_hit   = cfg_addr[7:2] == OFS_DATA[7:2];
  wire        wr_data  = cfg_wr && dw_hit && cfg_be[OFS_DATA[1:0]];
  wire        wr_waddr = cfg_wr && dw_hit && cfg_be[OFS_WADDR[1:0]];
  wire        wr_slave = cfg_wr && dw_hit && cfg_be[OFS_SLAVE[1:0]];
  wire        wr_csr   = cfg_wr && dw_hit && cfg_be[OFS_CSR[1:0]];
  wire [7:0]  csr_wr   = cfg_wdata[31:24];
  // Busy or absent interface swallows the start write
  wire        sw_launch = wr_slave && !load_active && present
                          && state == ST_IDLE;
  wire        is_read  = loading || slave_cmd[0];
  wire [6:0]  dev_addr = loading ? EE_SLAVE_ADDR : slave_cmd[7:1];
  wire        ack_slot = state == ST_DEVW || state == ST_WADDR
                         || state == ST_WDATA || state == ST_DEVR;
  wire        nack_evt = eng_done && ack_slot && !eng_ack;
  wire        rd_done  = eng_done && state == ST_RDATA;
  wire        stop_done = eng_done && state == ST_STOP;
  wire        bad_byte = rd_done && loading
                         && ((idx == IDX_FUNC && eng_rx != EE_FUNC_IND)
                         || (idx == IDX_COUNT && eng_rx != EE_COUNT)
                         || (idx == IDX_END && eng_rx != EE_END_MARK));
  wire [7:0]  csr_rd   = {skip_word_address, test_mode, sw_active, load_active,
                          present, 1'h0, sw_fault, load_fault};

  function automatic logic [8:0] map_offset(input logic [5:0] i);
    logic [8:0] r;
    r = 9'h000;
    for (int s = 0; s < SEG_COUNT; s++)
    begin
      if (i >= SEG_IDX[s] && i < SEG_IDX[s] + SEG_LEN[s])
        r = {1'h1, SEG_OFS[s] + 8'(i - SEG_IDX[s])};
    end
    return r;
  endfunction

  wire [8:0] map_hit = map_offset(idx);

  ////////////////////////////////////////////////////////////////////////////////
  // Command selection toward the engine

  assign eng_issue = state != ST_IDLE && !issued && !eng_busy;
  assign cmd_op    = (state == ST_START || state == ST_RSTART) ? OP_START
                   : (state == ST_STOP) ? OP_STOP
                   : (state == ST_RDATA) ? OP_READ : OP_WRITE;
  assign cmd_byte  = (state == ST_DEVW) ? {dev_addr, 1'h0}
                   : (state == ST_DEVR) ? {dev_addr, 1'h1}
                   : (state == ST_WADDR) ? (loading ? EE_WORD_START : word_address)
                   : (state == ST_WDATA) ? data_byte : RST_BYTE;
  // Master acks every image byte but the end marker or after an abort
  assign cmd_nack  = !loading || idx == IDX_END || abort;

  always_comb
  begin
    next_state = state;
    if (eng_done)
    begin
      unique case (state)
        ST_IDLE:   next_state = ST_IDLE;
        ST_START:  next_state = (is_read && skip_q) ? ST_DEVR : ST_DEVW;
        ST_DEVW:   next_state = !eng_ack ? ST_STOP
                              : skip_q ? ST_WDATA : ST_WADDR;
        ST_WADDR:  next_state = !eng_ack ? ST_STOP
                              : is_read ? ST_RSTART : ST_WDATA;
        ST_WDATA:  next_state = ST_STOP;
        ST_RSTART: next_state = ST_DEVR;
        ST_DEVR:   next_state = eng_ack ? ST_RDATA : ST_STOP;
        ST_RDATA:  next_state = cmd_nack ? ST_STOP : ST_RDATA;
        ST_STOP:   next_state = ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      issued <= 1'h0;
    else if (eng_done)
      issued <= 1'h0;
    else if (eng_issue)
      issued <= 1'h1;
  end

  // Strap sampling waits for the synchroniser to settle after release
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      settle     <= 2'h0;
      strap_done <= 1'h0;
    end
    else if (!strap_done)
    begin
      settle     <= settle + 2'h1;
      strap_done <= settle == PRESENT_SETTLE;
    end
  end

  wire strap_now = !strap_done && settle == PRESENT_SETTLE;
  wire auto_go   = strap_now && scl_in;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= ST_IDLE;
    else if (auto_go || sw_launch)
      state <= ST_START;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loading <= 1'h0;
      skip_q  <= 1'h0;
      idx     <= 6'h00;
      abort   <= 1'h0;
    end
    else if (auto_go || sw_launch)
    begin
      loading <= auto_go;
      skip_q  <= skip_word_address;
      idx     <= 6'h00;
      abort   <= 1'h0;
    end
    else if (rd_done)
    begin
      idx   <= idx + 6'h01;
      abort <= abort || bad_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags

  // Set from reset so the flag covers the strap window too
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      load_active <= 1'h1;
    else if ((strap_now && !scl_in) || (stop_done && loading))
      load_active <= 1'h0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      load_fault <= 1'h0;
    else if (bad_byte || (nack_evt && loading))
      load_fault <= 1'h1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sw_active <= 1'h0;
    else if (sw_launch)
      sw_active <= 1'h1;
    else if (stop_done && !loading)
      sw_active <= 1'h0;
  end

  // Event wins over the clear at launch
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sw_fault <= 1'h0;
    else if (nack_evt && !loading)
      sw_fault <= 1'h1;
    else if (sw_launch)
      sw_fault <= 1'h0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      present <= 1'h0;
    else if (strap_now)
      present <= scl_in;
    else if (wr_csr && !csr_wr[CSR_PRESENT])
      present <= 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers

  assign data_cap = rd_done && !loading;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      data_byte         <= RST_BYTE;
      word_address      <= RST_BYTE;
      slave_cmd         <= RST_BYTE;
      test_mode         <= 1'h0;
      skip_word_address <= 1'h0;
    end
    else
    begin
      if (data_cap)
        data_byte <= eng_rx;
      else if (wr_data)
        data_byte <= cfg_wdata[7:0];
      if (wr_waddr)
        word_address <= cfg_wdata[15:8];
      if (sw_launch)
        slave_cmd <= cfg_wdata[23:16];
      if (wr_csr)
      begin
        test_mode         <= csr_wr[CSR_TEST];
        skip_word_address <= csr_wr[CSR_SKIP];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cfg_rdata <= 32'h0000_0000;
    else if (cfg_rd)
      cfg_rdata <= dw_hit ? {csr_rd, slave_cmd, word_address, data_byte} : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration writes from the image

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      load_wr   <= 1'h0;
      load_addr <= RST_BYTE;
      load_data <= RST_BYTE;
    end
    else
    begin
      load_wr <= rd_done && loading && map_hit[8] && !abort;
      if (rd_done && loading)
      begin
        load_addr <= map_hit[7:0];
        load_data <= eng_rx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence launch_s;
    wr_slave && sw_launch;
  endsequence

  sequence image_byte_s(logic [5:0] n);
    rd_done && loading && !abort && idx == n;
  endsequence

  load_flag_a: assert property (loading && state != ST_IDLE |-> load_active)
    else $error("load flag low during download");
  bad_ind_a: assert property (image_byte_s(IDX_FUNC) ##0 eng_rx != EE_FUNC_IND
    |=> load_fault && abort)
    else $error("bad indicator not flagged");
  subsys_map_a: assert property (image_byte_s(6'h02) |=> load_wr && load_addr == 8'h44
    && load_data == $past(eng_rx))
    else $error("subsystem byte misplaced");
  skip_byte_a: assert property (image_byte_s(6'h0C) |=> !load_wr)
    else $error("reserved byte loaded");
  load_ignore_a: assert property (wr_slave && load_active |=> !sw_active)
    else $error("software start during load");
  sw_busy_a: assert property (launch_s |=> sw_active && state == ST_START)
    else $error("busy not raised on start");
  nack_fault_a: assert property (nack_evt && !loading |=> sw_fault ##1 state == ST_STOP)
    else $error("missing acknowledge not flagged");
  skip_addr_a: assert property (skip_q |-> state != ST_WADDR)
    else $error("word address sent while skipped");
  eeprom_addr_a: assert property (eng_issue && loading && state == ST_DEVW
    |-> cmd_byte == 8'hA0)
    else $error("wrong eeprom slave address");
  end_nack_a: assert property (eng_issue && loading && state == ST_RDATA
    && idx == IDX_END |-> cmd_nack)
    else $error("end marker acknowledged");

endmodule

/* tb/eeprom_model.sv */
// Behavioural two-wire EEPROM slave, 256 bytes, fixed address 1010 000b.
// Assumes the bench resolves both open-drain wires with pull-ups.
module eeprom_model
(
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic absent,
  output logic      pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic       ok;
  logic       more;
  int         bits;
  int         st;

  initial
  begin
    {pull, ok, more, sh, ptr} = '0;
    bits = 0;
    st = 4;
  end

  // States: 0 device byte, 1 word address, 2 write data, 3 read data, 4 idle
  always @(negedge sda)
    if (scl)
    begin
      bits = 0;
      st = 0;
    end

  always @(posedge sda)
    if (scl)
      st = 4;

  always @(posedge scl)
  begin
    if (st == 3 && bits == 8)
      more = !sda;
    else if (st < 3 && bits < 8)
      sh = {sh[6:0], sda};
    bits++;
  end

  // Line changes only while the clock is low
  always @(negedge scl)
  begin
    if (bits == 8 && st < 3)
    begin
      ok = !absent && (st != 0 || sh[7:1] == 7'h50);
      if (st == 1)
        ptr = sh;
      if (st == 2)
      begin
        mem[ptr] = sh;
        ptr++;
      end
    end
    else if (bits == 9)
    begin
      bits = 0;
      if (st < 3 && !ok)
        st = 4;
      else if (st == 0)
        st = sh[0] ? 3 : 1;
      else if (st == 1)
        st = 2;
      else if (st == 3 && !more)
        st = 4;
      if (st == 3)
      begin
        sh = mem[ptr];
        ptr++;
      end
    end
    pull = st == 3 ? (bits < 8 && !sh[7-bits]) : (st < 3 && bits == 8 && ok);
  end
endmodule

/* tb/tb_serial_eeprom_config_loader.sv */
// Bench for the EEPROM loader: download, software accesses and faults.
// Assumes the behavioural EEPROM model and pull-ups on both wires.
module tb_serial_eeprom_config_loader;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, cfg_wr, cfg_rd, absent, scl_pd, pull;
  logic        ld_wr, scl_oe, sda_oe;
  logic [7:0]  cfg_addr, ld_addr, ld_data, csr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, rdata, d;
  logic [7:0]  lw [256];
  int          nlw, miscompares, n_tests, cyc;
  wire         scl = !scl_oe && !scl_pd;
  wire         sda = !sda_oe && !pull;
  // Rows: image byte, length, configuration offset
  localparam logic [7:0] SEG [8][3] = '{'{8'h02, 8'h04, 8'h44}, '{8'h06, 8'h06, 8'hD4},
    '{8'h0D, 8'h02, 8'hDC}, '{8'h0F, 8'h0C, 8'hC0}, '{8'h1D, 8'h01, 8'hE0},
    '{8'h1E, 8'h02, 8'hE2}, '{8'h20, 8'h03, 8'hE8}, '{8'h23, 8'h04, 8'hEC}};

  // Short quarter keeps each download near 6300 cycles
  eeprom_config_loader #(.QUARTER(4)) DUT (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(rdata), .load_wr(ld_wr), .load_addr(ld_addr), .load_data(ld_data),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  eeprom_model u_ee (.scl(scl), .sda(sda), .absent(absent), .pull(pull));

  function automatic logic [7:0] img(int i);
    return 8'hC3 ^ i[7:0];
  endfunction

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic w(int ln, logic [7:0] v);
    @(posedge clk) #1 cfg_wr = 1'b1;
    cfg_be = 4'(1 << ln);
    cfg_wdata = {24'h0, v} << (8 * ln);
    @(posedge clk) #1 cfg_wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge clk) #1 cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk) #1 cfg_rd = 1'b0;
    cfg_addr = 8'hB0;
    d = rdata;
    csr = rdata[31:24];
  endtask

  task automatic wait_clear(int b);
    int k;
    k = 0;
    do
    begin
      rd(8'hB0);
      k++;
    end
    while (csr[b] !== 1'b0 && k < 5000);
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    nlw = 0;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic end_sim();
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk)
  begin
    if (ld_wr)
    begin
      lw[ld_addr] = ld_data;
      nlw++;
    end
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    {cfg_wr, cfg_rd, absent, scl_pd, cfg_be, cfg_wdata} = '0;
    cfg_addr = 8'hB0;
    miscompares = 0;
    n_tests = 0;
    cyc = 0;
    for (int i = 0; i < 256; i++)
      u_ee.mem[i] = img(i);
    u_ee.mem[0] = 8'h00;
    u_ee.mem[1] = 8'h25;
    u_ee.mem[8'h27] = 8'h80;
    do_reset();
    rd(8'hB0);
    chk("csr_load", 8'h18, csr);
    w(2, 8'hA0);
    rd(8'hB0);
    chk("csr_refused", 8'h18, csr);
    wait_clear(4);
    chk("csr_done", 8'h08, csr);
    chk("nload", 8'd34, nlw[7:0]);
    for (int r = 0; r < 8; r++)
      for (int k = 0; k < SEG[r][1]; k++)
        chk("load", img(SEG[r][0] + k), lw[SEG[r][2] + k]);
    w(1, 8'h30);
    w(0, 8'hA5);
    w(2, 8'hA0);
    rd(8'hB0);
    chk("sw_busy", 8'h28, csr);
    wait_clear(5);
    chk("sw_wr_csr", 8'h08, csr);
    chk("sw_wr_mem", 8'hA5, u_ee.mem[8'h30]);
    w(1, 8'h02);
    w(2, 8'hA1);
    wait_clear(5);
    chk("sw_rd", img(2), d[7:0]);
    rd(8'hB4);
    chk("unmapped", 8'h00, d[7:0]);
    absent = 1'b1;
    w(2, 8'hA0);
    wait_clear(5);
    chk("nack", 8'h0A, csr);
    absent = 1'b0;
    w(3, 8'hC8);
    w(2, 8'hA1);
    wait_clear(5);
    chk("skip_csr", 8'hC8, csr);
    chk("skip_rd", img(3), d[7:0]);
    u_ee.mem[1] = 8'h24;
    do_reset();
    wait_clear(4);
    chk("bad_csr", 8'h09, csr);
    chk("bad_nload", 8'd0, nlw[7:0]);
    u_ee.mem[1] = 8'h25;
    u_ee.mem[0] = 8'h01;
    do_reset();
    wait_clear(4);
    chk("bad_ind_csr", 8'h09, csr);
    chk("bad_ind_nload", 8'd0, nlw[7:0]);
    scl_pd = 1'b1;
    do_reset();
    rd(8'hB0);
    chk("absent_csr", 8'h00, csr);
    end_sim();
  end
endmodule
